//--- pin_mux_pkg.sv
// package: register map, field positions and reset values for the pin mux
package pin_mux_pkg;
    // ========================================================================
    // package variants
    localparam logic [0:0] PKG_20_PIN = 1'h0;
    localparam logic [0:0] PKG_28_PIN = 1'h1;

    // ========================================================================
    // register byte offsets (apb, one aligned word each)
    localparam logic [7:0] OFS_A_ENABLE  = 8'h00;
    localparam logic [7:0] OFS_A_SET_ONE = 8'h04;
    localparam logic [7:0] OFS_A_SET_TWO = 8'h08;
    localparam logic [7:0] OFS_B_ENABLE  = 8'h0C;
    localparam logic [7:0] OFS_B_SET_ONE = 8'h10;
    localparam logic [7:0] OFS_B_SET_TWO = 8'h14;
    localparam logic [7:0] OFS_C_ENABLE  = 8'h18;
    localparam logic [7:0] OFS_C_SET_ONE = 8'h1C;
    localparam logic [7:0] OFS_C_SET_TWO = 8'h20;
    localparam logic [7:0] OFS_D_ENABLE  = 8'h24;
    localparam logic [7:0] OFS_ROUTE_STS = 8'h28;

    // ========================================================================
    // reset values
    localparam logic [7:0] RST_ENABLE  = 8'h00;
    localparam logic [7:0] RST_SET     = 8'h00;
    localparam logic [7:0] RST_D_ENABLE = 8'h01;   // reset pin function on

    // ========================================================================
    // widths and field positions
    localparam int ADDR_W     = 8;
    localparam int PORT_W     = 8;
    localparam int B_BITS     = 4;
    localparam int C_BITS     = 4;
    localparam int STS_A_LSB  = 0;
    localparam int STS_B_LSB  = 8;
    localparam int STS_C_LSB  = 16;
    localparam int STS_D_LSB  = 24;
endpackage

//--- port_alt_function_select.sv
// port alternate function select: apb registers and per-pin routing
`timescale 1ns/1ps
// Behaviour
// (RULE_01) second set-select registers exist, read back, never steer routing
// (RULE_02) pin gets set-selected function only while its enable bit is set
// (RULE_03) port d has no set-select registers at all
// (RULE_04) port d enable bit connects pin straight to its one function
// (RULE_05) a0: timer 0 in/complement; a1: timer 0 out; value 1 reserved
// (RULE_06) a2 value 0 carries serial 0 driver enable; 1 reserved
// (RULE_07) a3 value 0 carries serial 0 clear-to-send; 1 reserved
// (RULE_08) a4 receive, a5 transmit on value 0; 1 reserved in 28-pin
// (RULE_09) 28-pin a6: timer 1 in or scl; a7: timer 1 out or sda
// (RULE_10) b0..b2 value 1 analog 0..2; b3 clock in (0) or analog 3
// (RULE_11) c0, c1 value 1 analog 4/5, comparator inputs, led drive
// (RULE_12) 20-pin c2 value 1 reference/analog 6/led; c3 comparator out or led
// (RULE_13) direction of an assigned pin comes from its peripheral
// (RULE_14) d0 leaves reset as reset pin; output-only as plain i/o
// (RULE_15) reserved choice connects nothing, peripheral input held inactive
// (RULE_16) package variant is a static parameter choosing the table
module port_alt_function_select
    import pin_mux_pkg::*;
#(
    parameter logic [0:0] PKG_VARIANT = pin_mux_pkg::PKG_28_PIN
) (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          reset_n,
    // apb slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [pin_mux_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // gpio side: data, direction from the port registers
    input  wire logic [pin_mux_pkg::PORT_W-1:0] gpio_a_out,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] gpio_a_oe,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] gpio_b_out,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] gpio_b_oe,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] gpio_c_out,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] gpio_c_oe,
    input  wire logic                          gpio_d0_out,
    // pads
    input  wire logic [pin_mux_pkg::PORT_W-1:0] pad_a_in,
    output logic      [pin_mux_pkg::PORT_W-1:0] pad_a_out,
    output logic      [pin_mux_pkg::PORT_W-1:0] pad_a_oe,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] pad_b_in,
    output logic      [pin_mux_pkg::PORT_W-1:0] pad_b_out,
    output logic      [pin_mux_pkg::PORT_W-1:0] pad_b_oe,
    output logic      [pin_mux_pkg::PORT_W-1:0] pad_b_analog,
    input  wire logic [pin_mux_pkg::PORT_W-1:0] pad_c_in,
    output logic      [pin_mux_pkg::PORT_W-1:0] pad_c_out,
    output logic      [pin_mux_pkg::PORT_W-1:0] pad_c_oe,
    output logic      [pin_mux_pkg::PORT_W-1:0] pad_c_analog,
    output logic      [pin_mux_pkg::PORT_W-1:0] pad_c_led,
    input  wire logic                          pad_d0_in,
    output logic                               pad_d0_out,
    output logic                               pad_d0_oe,
    // timers
    input  wire logic                          timer_zero_output,
    input  wire logic                          timer_zero_output_n,
    input  wire logic                          timer_zero_oe,
    output logic                               timer_zero_input,
    input  wire logic                          timer_one_output,
    input  wire logic                          timer_one_output_n,
    input  wire logic                          timer_one_oe,
    output logic                               timer_one_input,
    // serial port 0 (plain or infrared share the pins)
    input  wire logic                          serial_zero_driver_enable,
    output logic                               serial_zero_clear_to_send,
    output logic                               serial_zero_receive,
    input  wire logic                          serial_zero_transmit,
    // i2c, open drain: low is driven, high released
    input  wire logic                          i2c_scl_drive_low,
    output logic                               i2c_scl_in,
    input  wire logic                          i2c_sda_drive_low,
    output logic                               i2c_sda_in,
    // comparator, clock, reset
    input  wire logic                          comparator_zero_output,
    output logic                               external_clock_input,
    input  wire logic                          reset_drive_low,
    output logic                               external_reset_n
);
    import pin_mux_pkg::*;

    logic [PORT_W-1:0] a_en_r, a_set1_r, a_set2_r;
    logic [PORT_W-1:0] b_en_r, b_set1_r, b_set2_r;
    logic [PORT_W-1:0] c_en_r, c_set1_r, c_set2_r;
    logic [PORT_W-1:0] d_en_r;
    logic [PORT_W-1:0] a_route, b_route, c_route;
    logic              d0_route;
    logic              wr_en;
    logic              is_28;

    assign is_28 = (PKG_VARIANT == PKG_28_PIN);                 // [RULE_16]

    // ========================================================================
    // apb slave: zero wait states, unmapped offsets error
    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite;

    // ------------------------------------------------------------------------
    // register writes; set-two registers only store       [RULE_01]
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            a_en_r   <= RST_ENABLE;
            a_set1_r <= RST_SET;
            a_set2_r <= RST_SET;
            b_en_r   <= RST_ENABLE;
            b_set1_r <= RST_SET;
            b_set2_r <= RST_SET;
            c_en_r   <= RST_ENABLE;
            c_set1_r <= RST_SET;
            c_set2_r <= RST_SET;
            d_en_r   <= RST_D_ENABLE;                           // [RULE_14]
        end else if (wr_en) begin
            unique case (paddr)
                OFS_A_ENABLE:  a_en_r   <= pwdata[7:0];
                OFS_A_SET_ONE: a_set1_r <= pwdata[7:0];
                OFS_A_SET_TWO: a_set2_r <= pwdata[7:0];
                OFS_B_ENABLE:  b_en_r   <= pwdata[7:0];
                OFS_B_SET_ONE: b_set1_r <= pwdata[7:0];
                OFS_B_SET_TWO: b_set2_r <= pwdata[7:0];
                OFS_C_ENABLE:  c_en_r   <= pwdata[7:0];
                OFS_C_SET_ONE: c_set1_r <= pwdata[7:0];
                OFS_C_SET_TWO: c_set2_r <= pwdata[7:0];
                OFS_D_ENABLE:  d_en_r   <= pwdata[7:0];   // [RULE_03]
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // read data and error; status word shows live routing
    always_comb begin
        prdata  = 32'h0000_0000;
        pslverr = 1'b0;
        unique case (paddr)
            OFS_A_ENABLE:  prdata[7:0] = a_en_r;
            OFS_A_SET_ONE: prdata[7:0] = a_set1_r;
            OFS_A_SET_TWO: prdata[7:0] = a_set2_r;
            OFS_B_ENABLE:  prdata[7:0] = b_en_r;
            OFS_B_SET_ONE: prdata[7:0] = b_set1_r;
            OFS_B_SET_TWO: prdata[7:0] = b_set2_r;
            OFS_C_ENABLE:  prdata[7:0] = c_en_r;
            OFS_C_SET_ONE: prdata[7:0] = c_set1_r;
            OFS_C_SET_TWO: prdata[7:0] = c_set2_r;
            OFS_D_ENABLE:  prdata[7:0] = d_en_r;
            OFS_ROUTE_STS: begin
                prdata[STS_A_LSB +: 8] = a_route;
                prdata[STS_B_LSB +: 8] = b_route;
                prdata[STS_C_LSB +: 8] = c_route;
                prdata[STS_D_LSB]      = d0_route;
            end
            default:       pslverr = psel && penable;
        endcase
    end

    // ========================================================================
    // route valid: enable set and choice not reserved      [RULE_02] [RULE_15]
    always_comb begin
        // port a: bits 0..5 only on value 0, 6..7 both values in 28-pin
        for (int i = 0; i < 6; i++) begin
            a_route[i] = a_en_r[i] && !a_set1_r[i];      // [RULE_05] [RULE_08]
        end
        for (int i = 6; i < 8; i++) begin
            a_route[i] = a_en_r[i] && (!a_set1_r[i] || is_28);   // [RULE_09]
        end
        // port b: 0..2 analog only on 1, 3 both values        [RULE_10]
        b_route = '0;
        for (int i = 0; i < 3; i++) begin
            b_route[i] = b_en_r[i] && b_set1_r[i];
        end
        b_route[3] = b_en_r[3];
        // port c: 0..2 only on 1, 3 both values in 20-pin   [RULE_11] [RULE_12]
        c_route = '0;
        for (int i = 0; i < 3; i++) begin
            c_route[i] = c_en_r[i] && c_set1_r[i];
        end
        c_route[2] = c_route[2] && !is_28;       // 20-pin only
        c_route[3] = c_en_r[3] && !is_28;
        d0_route   = d_en_r[0];                                 // [RULE_04]
    end

    // ========================================================================
    // pad drive; peripheral supplies direction when routed       [RULE_13]
    always_comb begin
        pad_a_out = gpio_a_out;
        pad_a_oe  = gpio_a_oe;
        if (a_route[0]) begin
            pad_a_out[0] = timer_zero_output_n;
            pad_a_oe[0]  = timer_zero_oe;                       // [RULE_05]
        end
        if (a_route[1]) begin
            pad_a_out[1] = timer_zero_output;
            pad_a_oe[1]  = 1'b1;
        end
        if (a_route[2]) begin
            pad_a_out[2] = serial_zero_driver_enable;           // [RULE_06]
            pad_a_oe[2]  = 1'b1;
        end
        if (a_route[3]) begin
            pad_a_out[3] = 1'b0;                                // [RULE_07]
            pad_a_oe[3]  = 1'b0;
        end
        if (a_route[4]) begin
            pad_a_out[4] = 1'b0;                                // [RULE_08]
            pad_a_oe[4]  = 1'b0;
        end
        if (a_route[5]) begin
            pad_a_out[5] = serial_zero_transmit;
            pad_a_oe[5]  = 1'b1;
        end
        // open drain on i2c: drive low only                    [RULE_09]
        if (a_route[6]) begin
            pad_a_out[6] = a_set1_r[6] ? 1'b0 : timer_one_output_n;
            pad_a_oe[6]  = a_set1_r[6] ? i2c_scl_drive_low : timer_one_oe;
        end
        if (a_route[7]) begin
            pad_a_out[7] = a_set1_r[7] ? 1'b0 : timer_one_output;
            pad_a_oe[7]  = a_set1_r[7] ? i2c_sda_drive_low : 1'b1;
        end
        // port b: analog and clock in are all inputs           [RULE_10]
        pad_b_out    = gpio_b_out;
        pad_b_oe     = gpio_b_oe & ~b_route;
        pad_b_analog = '0;
        pad_b_analog[2:0] = b_route[2:0];
        pad_b_analog[3]   = b_route[3] && b_set1_r[3];
        // port c: comparator output on c3 value 0 in 20-pin, else led/analog
        pad_c_out    = gpio_c_out;
        pad_c_oe     = gpio_c_oe & ~c_route;
        pad_c_analog = '0;
        pad_c_led    = '0;
        pad_c_analog[2:0] = c_route[2:0];                       // [RULE_11]
        pad_c_led[2:0]    = c_route[2:0];
        if (c_route[3]) begin
            pad_c_out[3] = c_set1_r[3] ? 1'b0 : comparator_zero_output;
            pad_c_oe[3]  = !c_set1_r[3];                        // [RULE_12]
            pad_c_led[3] = c_set1_r[3];
        end
        // port d0: reset pin open drain, else output-only i/o  [RULE_14]
        pad_d0_out = d0_route ? 1'b0 : gpio_d0_out;
        pad_d0_oe  = d0_route ? reset_drive_low : 1'b1;         // [RULE_04]
    end

    // ========================================================================
    // peripheral inputs: inactive level unless routed           [RULE_15]
    always_comb begin
        timer_zero_input  = a_route[0] ? pad_a_in[0] : 1'b0;
        serial_zero_clear_to_send = a_route[3] ? pad_a_in[3] : 1'b1;
        serial_zero_receive = a_route[4] ? pad_a_in[4] : 1'b1;
        timer_one_input   = (a_route[6] && !a_set1_r[6]) ? pad_a_in[6] : 1'b0;
        i2c_scl_in        = (a_route[6] && a_set1_r[6]) ? pad_a_in[6] : 1'b1;
        i2c_sda_in        = (a_route[7] && a_set1_r[7]) ? pad_a_in[7] : 1'b1;
        external_clock_input = (b_route[3] && !b_set1_r[3]) ? pad_b_in[3]
                                                            : 1'b0;
        external_reset_n  = d0_route ? pad_d0_in : 1'b1;        // [RULE_04]
    end

    // c port pad inputs feed analog paths outside this block
    logic unused_c;
    assign unused_c = ^pad_c_in;
endmodule

//--- pin_mux_monitor.sv
// checker: pin routing against shadowed apb writes
`timescale 1ns/1ps
module pin_mux_monitor
    import pin_mux_pkg::*;
(
    // clock, reset and apb
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    // pins and peripherals
    input wire logic [7:0]  gpio_a_out,
    input wire logic [7:0]  pad_a_in,
    input wire logic [7:0]  pad_a_out,
    input wire logic [7:0]  pad_a_oe,
    input wire logic [7:0]  pad_b_analog,
    input wire logic [7:0]  pad_c_analog,
    input wire logic        pad_d0_in,
    input wire logic        pad_d0_oe,
    input wire logic        timer_zero_output,
    input wire logic        timer_zero_oe,
    input wire logic        serial_zero_driver_enable,
    input wire logic        serial_zero_clear_to_send,
    input wire logic        serial_zero_receive,
    input wire logic        serial_zero_transmit,
    input wire logic        reset_drive_low,
    input wire logic        external_reset_n
);
    logic [7:0] sh_r [0:9];
    // ========================================================================
    // shadow of the writable words; set-two words never steer, so unused
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < 10; i++) begin
                sh_r[i] <= (i == 9) ? RST_D_ENABLE : RST_SET;
            end
        end else if (psel && penable && pwrite && paddr < 8'h28 &&
                     paddr[1:0] == 2'h0) begin
            sh_r[paddr[5:2]] <= pwdata[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ========================================================================
    // routing relations
    chk_gpio_gate: assert property (!sh_r[0][2] |->
        pad_a_out[2] == gpio_a_out[2]) else $error("gpio not passed");
    chk_timer_out: assert property (sh_r[0][1] && !sh_r[1][1] |->
        pad_a_out[1] == timer_zero_output && pad_a_oe[1] == 1'b1)
        else $error("timer out wrong");
    chk_drv_enable: assert property (sh_r[0][2] && !sh_r[1][2] |->
        pad_a_out[2] == serial_zero_driver_enable) else $error("de wrong");
    chk_cts_route: assert property (sh_r[0][3] |->
        serial_zero_clear_to_send == (sh_r[1][3] | pad_a_in[3]))
        else $error("cts wrong");
    chk_rx_tx: assert property (sh_r[0][5:4] == 2'h3 &&
        sh_r[1][5:4] == 2'h0 |-> serial_zero_receive == pad_a_in[4] &&
        pad_a_out[5] == serial_zero_transmit) else $error("rx tx wrong");
    chk_analog_map: assert property (
        pad_b_analog[3:0] == (sh_r[3][3:0] & sh_r[4][3:0]) &&
        pad_c_analog[1:0] == (sh_r[6][1:0] & sh_r[7][1:0]))
        else $error("analog map wrong");
    chk_reset_pin: assert property (sh_r[9][0] |->
        pad_d0_oe == reset_drive_low && external_reset_n == pad_d0_in)
        else $error("reset pin wrong");
    chk_unmapped_err: assert property (psel && penable && paddr > 8'h28
        |-> pslverr) else $error("no slave error");
endmodule
bind port_alt_function_select pin_mux_monitor mon (.*);

//--- periph_model.sv
// partner: peripheral, port register and pad levels
`timescale 1ns/1ps
module periph_model (
    // clock
    input  wire logic clk,
    // port registers and pads
    output logic [7:0] gpio_a_out,
    output logic [7:0] gpio_a_oe,
    output logic [7:0] gpio_b_out,
    output logic [7:0] gpio_b_oe,
    output logic [7:0] gpio_c_out,
    output logic [7:0] gpio_c_oe,
    output logic       gpio_d0_out,
    output logic [7:0] pad_a_in,
    output logic [7:0] pad_b_in,
    output logic [7:0] pad_c_in,
    output logic       pad_d0_in,
    // peripheral levels
    output logic [11:0] lv
);
    logic [7:0] n_r = 8'h00;
    // levels change every cycle so a stale route cannot match by luck
    always_ff @(posedge clk) begin
        n_r <= n_r + 8'h03;
    end
    assign {gpio_a_out, gpio_a_oe} = {n_r, ~n_r};
    assign {gpio_b_out, gpio_b_oe} = {n_r ^ 8'h5A, n_r};
    assign {gpio_c_out, gpio_c_oe} = {~n_r, n_r ^ 8'hC3};
    assign {pad_a_in, pad_b_in, pad_c_in} = {n_r ^ 8'h96, ~n_r, n_r};
    assign {gpio_d0_out, pad_d0_in} = {n_r[1], n_r[2]};
    assign lv = {n_r[3:0], n_r ^ 8'hA5};
endmodule

//--- port_alt_function_select_test.sv
// testbench: apb access and routing checks for the pin mux
`timescale 1ns/1ps
module port_alt_function_select_test;
    import pin_mux_pkg::*;
    logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, sl;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, gpio_d0_out, pad_d0_in, pad_d0_out, pad_d0_oe;
    logic [7:0] gpio_a_out, gpio_a_oe, gpio_b_out, gpio_b_oe, gpio_c_out;
    logic [7:0] gpio_c_oe, pad_a_in, pad_b_in, pad_c_in, pad_a_out, pad_a_oe;
    logic [7:0] pad_b_out, pad_b_oe, pad_b_analog, pad_c_out, pad_c_oe;
    logic [7:0] pad_c_analog, pad_c_led;
    logic [11:0] lv;
    logic timer_zero_input, timer_one_input, serial_zero_clear_to_send;
    logic serial_zero_receive, i2c_scl_in, i2c_sda_in;
    logic external_clock_input, external_reset_n;
    int error_cnt = 0, total_checks = 0;
    always #50 clk = ~clk;
    periph_model pm (.*);
    port_alt_function_select #(.PKG_VARIANT(PKG_28_PIN)) uut (.*,
        .timer_zero_output(lv[0]), .timer_zero_output_n(lv[1]),
        .timer_zero_oe(lv[2]), .timer_one_output(lv[3]),
        .timer_one_output_n(lv[4]), .timer_one_oe(lv[5]),
        .serial_zero_driver_enable(lv[6]), .serial_zero_transmit(lv[7]),
        .i2c_scl_drive_low(lv[8]), .i2c_sda_drive_low(lv[9]),
        .comparator_zero_output(lv[10]), .reset_drive_low(lv[11]));
    // ========================================================================
    // one apb transfer; waits on pready under a bound
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            results();
        end
        rd = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // writes land at the edge; checks sample the settled mid-cycle
        @(negedge clk);
    endtask
    // compare values the caller captured at mid-cycle
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ========================================================================
    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0000_0000);
            chk(rd, (i == 9) ? 32'h0000_0001 : 32'h0000_0000);
        end
        apb(1'b0, OFS_ROUTE_STS, 32'h0000_0000);
        chk(rd, 32'h0100_0000);
        chk(external_reset_n, pad_d0_in);
        apb(1'b0, 8'h2C, 32'h0000_0000);
        chk({rd[30:0], sl}, 32'h0000_0001);
        chk({pad_a_out, pad_a_oe}, {gpio_a_out, gpio_a_oe});
        $display("reset and gpio test done");
        apb(1'b1, OFS_A_ENABLE, 32'h0000_00FF);
        chk(timer_zero_input, pad_a_in[0]);
        chk({pad_a_out[0], pad_a_oe[0]}, {lv[1], lv[2]});
        chk({pad_a_out[1], pad_a_oe[1]}, {lv[0], 1'b1});
        chk(pad_a_out[2], lv[6]);
        chk(serial_zero_clear_to_send, pad_a_in[3]);
        chk(serial_zero_receive, pad_a_in[4]);
        chk(pad_a_out[5], lv[7]);
        chk(pad_a_oe[4:3], 2'h0);
        chk(timer_one_input, pad_a_in[6]);
        chk(pad_a_out[7:6], {lv[3], lv[4]});
        chk(pad_a_oe[7:6], {1'b1, lv[5]});
        apb(1'b1, OFS_A_SET_TWO, 32'h0000_00FF);
        apb(1'b0, OFS_A_SET_TWO, 32'h0000_0000);
        chk(rd, 32'h0000_00FF);
        chk(serial_zero_clear_to_send, pad_a_in[3]);
        $display("port a function test done");
        apb(1'b1, OFS_A_SET_ONE, 32'h0000_00FF);
        chk(serial_zero_clear_to_send, 1'b1);
        chk(serial_zero_receive, 1'b1);
        chk(timer_zero_input, 1'b0);
        chk(pad_a_out[2], gpio_a_out[2]);
        chk({i2c_scl_in, pad_a_oe[7]}, {pad_a_in[6], lv[9]});
        chk({i2c_sda_in, pad_a_oe[6]}, {pad_a_in[7], lv[8]});
        chk({timer_one_input, pad_a_out[7:6]}, 3'h0);
        $display("reserved and i2c test done");
        apb(1'b1, OFS_B_ENABLE, 32'h0000_000F);
        apb(1'b1, OFS_B_SET_ONE, 32'h0000_0007);
        chk(pad_b_analog[3:0], 4'h7);
        chk(external_clock_input, pad_b_in[3]);
        chk(pad_b_oe, gpio_b_oe & 8'hF0);
        chk(pad_b_out, gpio_b_out);
        apb(1'b1, OFS_B_SET_ONE, 32'h0000_000F);
        chk({pad_b_analog[3:0], external_clock_input}, 5'h1E);
        apb(1'b1, OFS_C_ENABLE, 32'h0000_0003);
        apb(1'b1, OFS_C_SET_ONE, 32'h0000_0003);
        chk(pad_c_analog[1:0], 2'h3);
        chk(pad_c_led[1:0], 2'h3);
        chk(pad_c_oe, gpio_c_oe & 8'hFC);
        chk(pad_c_out, gpio_c_out);
        apb(1'b1, OFS_D_ENABLE, 32'h0000_0000);
        chk(pad_d0_out, gpio_d0_out);
        chk(pad_d0_oe, 1'b1);
        chk(external_reset_n, 1'b1);
        apb(1'b1, OFS_ROUTE_STS, 32'hFFFF_FFFF);
        apb(1'b0, OFS_ROUTE_STS, 32'h0000_0000);
        chk(rd, 32'h0003_0FC0);
        // mid-run reset must bring the reset pin function back
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        apb(1'b0, OFS_D_ENABLE, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        apb(1'b0, OFS_A_ENABLE, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(external_reset_n, pad_d0_in);
        $display("port b c d test done");
        results();
    end
endmodule
